// ---- include/ucr_cfg.svh ----
// Constants of the unblock carrier receiver logic
// *****************************************************************
// *****************************************************************
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH

// Timing
`define UCR_CLK_HZ          125000000
`define UCR_TICK_CYC        (`UCR_CLK_HZ / 1000)
`define UCR_WINDOW_MS       150
`define UCR_OPEN_BRK_MS     1000

// APB register byte addresses
`define UCR_ADDR_CTRL       12'h000
`define UCR_ADDR_STATUS     12'h004
`define UCR_ADDR_IRQ_STAT   12'h008
`define UCR_ADDR_IRQ_MASK   12'h00C

// Control field positions and reset value
`define UCR_CTRL_ENABLE     0
`define UCR_CTRL_NONPERM    1
`define UCR_CTRL_RESET      32'h0000_0001

// Event bits (status, irq status and mask share this layout)
`define UCR_EV_LOCKOUT      0
`define UCR_EV_ALARM        1
`define UCR_EV_TRIP         2
`define UCR_EV_OPENBRK      3
`define UCR_EV_WIDTH        4

`endif

// ---- include/ucr_pkg.sv ----
// Types of the unblock carrier receiver logic
package ucr_pkg;

   // Channel supervision states
   typedef enum logic [3:0] {
      UCR_NORMAL  = 4'b0001,
      UCR_WINDOW  = 4'b0010,
      UCR_NOCHAN  = 4'b0100,
      UCR_LOCKED  = 4'b1000
   } ucr_chan_e;

endpackage : ucr_pkg

// ---- include/ucr_sync_if.sv ----
// Bundle of synchronised carrier and relay inputs
`timescale 1ns/100ps
interface ucr_sync_if;
   logic blockRx;
   logic unblockRx;
   logic transferRx;
   logic openBrkRx;
   logic tripDet;
   logic permDet;
   logic underDet;

   modport src (output blockRx, unblockRx, transferRx, openBrkRx,
                tripDet, permDet, underDet);
   modport dst (input  blockRx, unblockRx, transferRx, openBrkRx,
                tripDet, permDet, underDet);
endinterface : ucr_sync_if

// ---- rtl/ucr_in_sync.sv ----
// Three-stage synchroniser for the carrier and relay pins
`timescale 1ns/100ps
module ucr_in_sync #(
   parameter int N = 7
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [N-1:0] pinIn,
   ucr_sync_if.src           sy
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] q;
   } ucr_sync_s;

   ucr_sync_s st_ff;
   ucr_sync_s nxt_st;

   // Stage one feeds only stage two; a value is taken once 2 and 3 agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = pinIn;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < N; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s3[i];
         end
      end
   end

   // Synchronous reset to all zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sy.blockRx    = st_ff.q[0];
   assign sy.unblockRx  = st_ff.q[1];
   assign sy.transferRx = st_ff.q[2];
   assign sy.openBrkRx  = st_ff.q[3];
   assign sy.tripDet    = st_ff.q[4];
   assign sy.permDet    = st_ff.q[5];
   assign sy.underDet   = st_ff.q[6];
endmodule : ucr_in_sync

// ---- rtl/ucr_receiver_logic.sv ----
// Unblock carrier receiver trip logic with APB registers
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "ucr_cfg.svh"
module ucr_receiver_logic #(
   parameter int TICK_CYC   = `UCR_TICK_CYC,
   parameter int WINDOW_MS  = `UCR_WINDOW_MS,
   parameter int OPENBRK_MS = `UCR_OPEN_BRK_MS
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        nearBlockPin,
   input  wire logic        nearUnblockPin,
   input  wire logic        farTransferPin,
   input  wire logic        openBreakerPin,
   input  wire logic        tripDetPin,
   input  wire logic        permissiveFaultDetectorPin,
   input  wire logic        underreachDetPin,
   output logic             receiverTripRelay,
   output logic             breakerTrip,
   output logic             transferKey,
   output logic             channelAlarm,
   output logic             lockout,
   output logic             irq
);
   // *****************************************************************
   // Types and state
   // *****************************************************************
   localparam int TW = $clog2(TICK_CYC);
   localparam int MW = $clog2(OPENBRK_MS + 1);

   typedef struct packed {
      ucr_pkg::ucr_chan_e               chan;
      logic [TW-1:0]                    tickCnt;
      logic                             tick;
      logic [MW-1:0]                    winMs;
      logic [MW-1:0]                    obMs;
      logic                             openBrk;
      logic                             alarm;
      logic                             permit;
      logic                             trip;
      logic                             key;
      logic [31:0]                      ctrl;
      logic [`UCR_EV_WIDTH-1:0]         irqStat;
      logic [`UCR_EV_WIDTH-1:0]         irqMask;
      logic [31:0]                      rdata;
   } ucr_state_s;

   ucr_state_s st_ff;
   ucr_state_s nxt_st;

   ucr_sync_if sy ();

   logic [`UCR_EV_WIDTH-1:0] evSet;
   logic [`UCR_EV_WIDTH-1:0] evNow;
   logic                     wrEn;
   logic                     rdEn;
   logic                     addrOk;
   logic                     enable;
   logic                     nonPerm;
   logic                     chanPermit;
   logic                     tripNow;

   // *****************************************************************
   // Input synchronisers
   // *****************************************************************
   ucr_in_sync #(
      .N (7)
   ) u_sync (
      .clk   (clk),
      .nrst  (nrst),
      .pinIn ({underreachDetPin, permissiveFaultDetectorPin, tripDetPin,
               openBreakerPin, farTransferPin, nearUnblockPin,
               nearBlockPin}),
      .sy    (sy)
   );

   // *****************************************************************
   // APB decode
   // *****************************************************************
   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign addrOk  = (paddr == `UCR_ADDR_CTRL) ||
                    (paddr == `UCR_ADDR_STATUS) ||
                    (paddr == `UCR_ADDR_IRQ_STAT) ||
                    (paddr == `UCR_ADDR_IRQ_MASK);
   assign pslverr = psel && penable && !addrOk;
   assign wrEn    = psel && penable && pwrite && addrOk;
   assign rdEn    = psel && !penable && !pwrite;
   assign enable  = st_ff.ctrl[`UCR_CTRL_ENABLE];
   assign nonPerm = st_ff.ctrl[`UCR_CTRL_NONPERM];

   // Channel permission: unblock direct, or the open window
   assign chanPermit = enable && (sy.unblockRx ||
                       st_ff.chan == ucr_pkg::UCR_WINDOW);

   // Trip sources of the local breaker
   always_comb begin
      tripNow = 1'b0;
      if (enable) begin
         tripNow = (chanPermit && sy.tripDet)
                || (st_ff.openBrk && sy.tripDet)
                || sy.underDet
                || (sy.transferRx && (sy.permDet || nonPerm));
      end
   end

   assign evNow = {st_ff.openBrk, st_ff.trip, st_ff.alarm,
                   st_ff.chan == ucr_pkg::UCR_LOCKED};

   // *****************************************************************
   // Next-state logic
   // *****************************************************************
   always_comb begin
      nxt_st = st_ff;

      // Single millisecond tick from the system clock
      nxt_st.tick = 1'b0;
      if (st_ff.tickCnt == TW'(TICK_CYC - 1)) begin
         nxt_st.tickCnt = '0;
         nxt_st.tick    = 1'b1;
      end else begin
         nxt_st.tickCnt = st_ff.tickCnt + 1'b1;
      end

      // Channel supervision
      unique case (st_ff.chan)
         ucr_pkg::UCR_NORMAL: begin
            nxt_st.winMs = '0;
            if (!sy.blockRx && !sy.unblockRx) begin
               nxt_st.chan = ucr_pkg::UCR_WINDOW;
            end
         end
         ucr_pkg::UCR_WINDOW: begin
            if (sy.unblockRx || sy.blockRx) begin
               // Unblock or returning block ends the window and resets the timer
               nxt_st.chan  = ucr_pkg::UCR_NORMAL;
               nxt_st.winMs = '0;
            end else if (st_ff.tick) begin
               if (st_ff.winMs == MW'(WINDOW_MS - 1)) begin
                  nxt_st.chan  = ucr_pkg::UCR_LOCKED;
                  nxt_st.alarm = 1'b1;
               end else begin
                  nxt_st.winMs = st_ff.winMs + 1'b1;
               end
            end
         end
         ucr_pkg::UCR_NOCHAN: begin
            // Unused transit code; return to monitoring
            nxt_st.chan = ucr_pkg::UCR_NORMAL;
         end
         ucr_pkg::UCR_LOCKED: begin
            if (sy.blockRx) begin
               nxt_st.chan  = ucr_pkg::UCR_NORMAL;
               nxt_st.alarm = 1'b0;
               nxt_st.winMs = '0;
               nxt_st.obMs  = '0;
            end
         end
         default: begin
            nxt_st.chan = ucr_pkg::UCR_NORMAL;
         end
      endcase

      // Remote open breaker: held signal for the full interval
      if (!sy.openBrkRx) begin
         nxt_st.obMs    = '0;
         nxt_st.openBrk = 1'b0;
      end else if (st_ff.tick && !st_ff.openBrk) begin
         if (st_ff.obMs == MW'(OPENBRK_MS - 1)) begin
            nxt_st.openBrk = 1'b1;
         end else begin
            nxt_st.obMs = st_ff.obMs + 1'b1;
         end
      end

      // Registered outputs
      // Follows the next channel state so lockout withdraws it at once
      nxt_st.permit = enable && (sy.unblockRx ||
                      nxt_st.chan == ucr_pkg::UCR_WINDOW);
      nxt_st.trip   = tripNow;
      nxt_st.key    = enable && sy.underDet;

      // Register writes
      if (wrEn && paddr == `UCR_ADDR_CTRL) begin
         nxt_st.ctrl = {30'h0000_0000, pwdata[1:0]};
      end
      if (wrEn && paddr == `UCR_ADDR_IRQ_MASK) begin
         nxt_st.irqMask = pwdata[`UCR_EV_WIDTH-1:0];
      end
      // Write one to clear; a new event in the same cycle wins
      if (wrEn && paddr == `UCR_ADDR_IRQ_STAT) begin
         nxt_st.irqStat = st_ff.irqStat & ~pwdata[`UCR_EV_WIDTH-1:0];
      end
      // Rising edges of the status conditions are the interrupt events
      evSet = {!st_ff.openBrk && nxt_st.openBrk,
               !st_ff.trip && nxt_st.trip,
               !st_ff.alarm && nxt_st.alarm,
               st_ff.chan != ucr_pkg::UCR_LOCKED &&
               nxt_st.chan == ucr_pkg::UCR_LOCKED};
      nxt_st.irqStat = nxt_st.irqStat | evSet;

      // Read data captured in setup, presented in the access phase
      if (rdEn) begin
         unique case (paddr)
            `UCR_ADDR_CTRL:     nxt_st.rdata = st_ff.ctrl;
            `UCR_ADDR_STATUS:   nxt_st.rdata = {28'h000_0000, evNow};
            `UCR_ADDR_IRQ_STAT: nxt_st.rdata = {28'h000_0000,
                                                st_ff.irqStat};
            `UCR_ADDR_IRQ_MASK: nxt_st.rdata = {28'h000_0000,
                                                st_ff.irqMask};
            default:            nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // *****************************************************************
   // State register
   // *****************************************************************
   // Synchronous reset clears timers, lockout and alarm
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_ff         <= '0;
         st_ff.chan    <= ucr_pkg::UCR_NORMAL;
         st_ff.ctrl    <= `UCR_CTRL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // *****************************************************************
   // Outputs
   // *****************************************************************
   assign prdata            = st_ff.rdata;
   assign receiverTripRelay = st_ff.permit;
   assign breakerTrip       = st_ff.trip;
   assign transferKey       = st_ff.key;
   assign channelAlarm      = st_ff.alarm;
   assign lockout           = evNow[`UCR_EV_LOCKOUT];
   assign irq               = |(st_ff.irqStat & st_ff.irqMask);
endmodule : ucr_receiver_logic

// ---- tb/testbench.sv ----
// Self-checking bench of the receiver trip logic
`timescale 1ns/100ps
`include "ucr_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, blk, unb, boost, irq;
   logic        fault = 0, shrt = 0, dead = 0;
   logic        xfr = 0, obk = 0, det = 0, pd = 0, und = 0;
   logic        rel, trip, key, alarm, lock;
   int          fails = 0, n_checks = 0, np = 0, obl = 0, g;

   initial forever #4 clk = ~clk;
   ucr_far_end i_ucr_far_end (.clk(clk), .remoteFault(fault),
      .pathShorted(shrt), .chanDead(dead), .nearBlockPin(blk),
      .nearUnblockPin(unb), .powerBoost(boost));
   // Short counts keep the run brief; expectations follow them
   ucr_receiver_logic #(.TICK_CYC(10), .WINDOW_MS(5), .OPENBRK_MS(8))
   i_ucr_receiver_logic (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nearBlockPin(blk), .nearUnblockPin(unb), .farTransferPin(xfr),
      .openBreakerPin(obk), .tripDetPin(det),
      .permissiveFaultDetectorPin(pd), .underreachDetPin(und),
      .receiverTripRelay(rel), .breakerTrip(trip), .transferKey(key),
      .channelAlarm(alarm), .lockout(lock), .irq(irq));

   // ***************************************
   // Model and helpers
   // ***************************************
   function automatic logic exp_trip(input int r);
      return (r[0] && det) || und || (xfr && (pd || np[0])) || (obl[0] && det);
   endfunction : exp_trip

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic se);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         fails++;
         print_verdict();
      end
      if (!w) `CHK(prdata, e)
      `CHK(pslverr, se)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Outputs are compared off the edge, where they have settled
   task automatic check_all(input int r, input int l);
      @(negedge clk);
      `CHK(rel, r[0])
      `CHK(lock, l[0])
      `CHK(alarm, l[0])
      `CHK(trip, exp_trip(r))
      `CHK(key, und)
      @(posedge clk);
   endtask : check_all

   task automatic chk_irq(input logic e);
      @(negedge clk);
      `CHK(irq, e)
      @(posedge clk);
   endtask : chk_irq

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      void'($urandom(32'h3334_a63b));
      cyc(5);
      nrst <= 1'b1;
      @(posedge clk);
      apb(0, `UCR_ADDR_CTRL, '0, `UCR_CTRL_RESET, 0);
      apb(0, `UCR_ADDR_IRQ_MASK, '0, '0, 0);
      apb(0, 12'h010, '0, '0, 1);
      apb(1, 12'h010, '1, '0, 1);
      cyc(20);
      check_all(0, 0);
      $display("test block done");
      fault <= 1'b1;
      det <= 1'b1;
      cyc(12);
      check_all(1, 0);
      cyc(80);
      check_all(1, 0);
      fault <= 1'b0;
      det <= 1'b0;
      cyc(12);
      check_all(0, 0);
      $display("test unblock done");
      // Fault shorts the unblock tone for less than the window
      shrt <= 1'b1;
      fault <= 1'b1;
      g = $urandom_range(30, 20);
      cyc(g);
      check_all(1, 0);
      fault <= 1'b0;
      cyc(12);
      check_all(0, 0);
      dead <= 1'b1;
      cyc(80);
      check_all(0, 1);
      chk_irq(1'b0);
      apb(0, `UCR_ADDR_STATUS, '0, 32'h0000_0003, 0);
      apb(1, `UCR_ADDR_IRQ_MASK, 32'h0000_0003, '0, 0);
      chk_irq(1'b1);
      apb(1, `UCR_ADDR_IRQ_STAT, $urandom() | 32'h0000_000F, '0, 0);
      chk_irq(1'b0);
      dead <= 1'b0;
      shrt <= 1'b0;
      fault <= 1'b1;
      cyc(12);
      check_all(1, 1);
      fault <= 1'b0;
      cyc(12);
      check_all(0, 0);
      $display("test outage done");
      // Transfer tone in both schemes, with and without the detector
      for (int m = 0; m < 4; m++) begin
         np = m / 2;
         apb(1, `UCR_ADDR_CTRL, 32'(2 * np + 1), '0, 0);
         pd <= m[0];
         xfr <= 1'b1;
         cyc(8);
         check_all(0, 0);
         xfr <= 1'b0;
         cyc(8);
      end
      apb(1, `UCR_ADDR_CTRL, `UCR_CTRL_RESET, '0, 0);
      np = 0;
      pd <= 1'b0;
      und <= 1'b1;
      cyc(8);
      check_all(0, 0);
      und <= 1'b0;
      cyc(8);
      $display("test transfer done");
      det <= 1'b1;
      obk <= 1'b1;
      cyc(40);
      check_all(0, 0);
      cyc(70);
      obl = 1;
      check_all(0, 0);
      apb(0, `UCR_ADDR_STATUS, '0, 32'h0000_000C, 0);
      det <= 1'b0;
      obk <= 1'b0;
      obl = 0;
      $display("test open breaker done");
      // Reset in mid-run while locked out
      dead <= 1'b1;
      cyc(80);
      check_all(0, 1);
      nrst <= 1'b0;
      cyc(4);
      nrst <= 1'b1;
      dead <= 1'b0;
      check_all(0, 0);
      $display("test reset done");
      print_verdict();
   end
endmodule : testbench

// ---- tb/ucr_far_end.sv ----
// Remote transmitter as seen through the local tone detectors
`timescale 1ns/100ps
module ucr_far_end (
   input  wire logic clk,
   input  wire logic remoteFault,
   input  wire logic pathShorted,
   input  wire logic chanDead,
   output logic      nearBlockPin = 1'b0,
   output logic      nearUnblockPin = 1'b0,
   output logic      powerBoost = 1'b0
);
   // Block tone unless faulted; a dead channel carries no tone at all
   always @(posedge clk) begin
      powerBoost <= remoteFault;
      nearBlockPin <= !remoteFault && !chanDead;
      nearUnblockPin <= remoteFault && !pathShorted && !chanDead;
   end
endmodule : ucr_far_end

// ---- tb/ucr_monitor.sv ----
// Port checker of the receiver trip logic, bound to its top module
`timescale 1ns/100ps
module ucr_monitor #(
   parameter int TICK_CYC   = 10,
   parameter int WINDOW_MS  = 5,
   parameter int OPENBRK_MS = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic nearBlockPin,
   input wire logic nearUnblockPin,
   input wire logic farTransferPin,
   input wire logic openBreakerPin,
   input wire logic tripDetPin,
   input wire logic permissiveFaultDetectorPin,
   input wire logic underreachDetPin,
   input wire logic receiverTripRelay,
   input wire logic breakerTrip,
   input wire logic transferKey,
   input wire logic channelAlarm,
   input wire logic lockout
);
   // Slack of one tick phase plus synchroniser delay
   localparam int WLO = (WINDOW_MS - 1) * TICK_CYC - 3;
   localparam int WHI = (WINDOW_MS + 1) * TICK_CYC + 3;
   localparam int OBL = (OPENBRK_MS + 1) * TICK_CYC + 6;
   int relCnt_ff;
   int obCnt_ff;
   // Run lengths of the relay output and of the open-breaker pin
   always_ff @(posedge clk) begin
      relCnt_ff <= (nrst && receiverTripRelay) ? relCnt_ff + 1 : 0;
      obCnt_ff  <= (nrst && openBreakerPin) ? obCnt_ff + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ***************************************
   // Channel supervision
   // ***************************************
   AST_BLOCK_QUIET: assert property (
      (nearBlockPin && !nearUnblockPin)[*8]
      |-> !receiverTripRelay && !lockout && !channelAlarm)
      else $error("block tone present but permission or lockout set");
   AST_UNBLOCK: assert property (nearUnblockPin[*8]
      |-> receiverTripRelay) else $error("unblock gave no permission");
   AST_UNBLOCK_NOLOCK: assert property (nearUnblockPin[*8]
      |=> !$rose(lockout)) else $error("lockout while unblock present");
   AST_WIN_LEN: assert property ($rose(lockout)
      |-> $fell(receiverTripRelay) && relCnt_ff inside {[WLO:WHI]})
      else $error("window length or withdrawal wrong at lockout");
   AST_ALARM: assert property ($rose(lockout) |-> channelAlarm)
      else $error("lockout without alarm");
   AST_RST: assert property ($rose(nrst)
      |-> !lockout && !channelAlarm && !receiverTripRelay)
      else $error("state not cleared by reset");
   // ***************************************
   // Trip paths
   // ***************************************
   AST_NO_PERM: assert property (
      (!receiverTripRelay && !underreachDetPin && !farTransferPin
      && !openBreakerPin)[*7] |-> !breakerTrip)
      else $error("trip without any permission");
   AST_PERM_TRIP: assert property (
      (receiverTripRelay && tripDetPin)[*6] |-> breakerTrip)
      else $error("permission and detector gave no trip");
   AST_OPEN_BRK: assert property (
      (obCnt_ff > OBL && tripDetPin)[*6] |-> breakerTrip)
      else $error("open breaker did not allow local trip");
   AST_UNDER: assert property (underreachDetPin[*6]
      |-> breakerTrip && transferKey)
      else $error("underreach did not trip and key");
   AST_XFER: assert property (
      (farTransferPin && permissiveFaultDetectorPin)[*6] |-> breakerTrip)
      else $error("transfer tone with detector gave no trip");
endmodule : ucr_monitor

bind ucr_receiver_logic ucr_monitor #(.TICK_CYC(TICK_CYC),
   .WINDOW_MS(WINDOW_MS), .OPENBRK_MS(OPENBRK_MS)) i_ucr_monitor (
   .clk(clk), .nrst(nrst), .nearBlockPin(nearBlockPin),
   .nearUnblockPin(nearUnblockPin), .farTransferPin(farTransferPin),
   .openBreakerPin(openBreakerPin), .tripDetPin(tripDetPin),
   .permissiveFaultDetectorPin(permissiveFaultDetectorPin),
   .underreachDetPin(underreachDetPin),
   .receiverTripRelay(receiverTripRelay), .breakerTrip(breakerTrip),
   .transferKey(transferKey), .channelAlarm(channelAlarm),
   .lockout(lockout));
